// *** common/bio_map.svh ***
/*
  constants for the bidirectional port block: file addresses, reset
  values, widths.
  assumes inclusion by bare name from the design files.
*/
`ifndef BIO_MAP_SVH
`define BIO_MAP_SVH

`define BIO_ADDR_GROUP_A  5'h05
`define BIO_ADDR_GROUP_B  5'h06
`define BIO_ADDR_GROUP_C  5'h07
`define BIO_DIR_RESET     8'hFF
`define BIO_LATCH_RESET   8'h00
`define BIO_GROUP_A_MASK  8'h0F
`define BIO_ZERO          8'h00

`endif

// *** common/bio_pkg.sv ***
/*
  types for the bidirectional port block.
  assumes bio_map.svh holds the numeric constants.
*/
package bio_pkg;

  typedef logic [7:0] bio_byte_t;
  typedef logic [4:0] bio_faddr_t;

  // one core access, presented for one instruction cycle
  typedef struct packed {
    logic       rd;      // sample pins at start of cycle
    logic       wr;      // write latch at end of cycle
    logic       dir_ld;  // direction load from working register
    logic       bit_op;  // bit set / bit clear (read-modify-write)
    logic       bit_val; // 1 = set, 0 = clear
    logic [2:0] bit_sel;
    bio_faddr_t addr;
    bio_byte_t  wdata;   // working register or result
  } bio_req_s;

  typedef struct packed {
    bio_byte_t out;
    bio_byte_t oe;
  } bio_pins_s;

endpackage

// *** hw/bio_sync.sv ***
/*
  three-stage pin synchroniser; a change counts once stages two and
  three agree.
  assumes an asynchronous pin input vector of eight bits.
*/
`include "bio_map.svh"

module bio_sync
  import bio_pkg::*;
(
  // clock and reset
  input  wire logic      ref_clk,
  input  wire logic      rst_n,
  // pins in, filtered level out
  input  wire bio_byte_t pin_in,
  output bio_byte_t      level_q
);

  bio_byte_t s1_q;
  bio_byte_t s2_q;
  bio_byte_t s3_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= `BIO_ZERO;
      s2_q <= `BIO_ZERO;
      s3_q <= `BIO_ZERO;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a bit moves only once two stages agree, so a one-cycle glitch dies
  // here; one process owns the whole vector
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= `BIO_ZERO;
    end else begin
      level_q <= (s3_q & ~(s2_q ^ s3_q)) | (level_q & (s2_q ^ s3_q));
    end
  end

endmodule // bio_sync

// *** hw/bio_ports.sv ***
/*
  bidirectional I/O ports: group a (4 bits), group b and group c
  (8 bits each), each with an output latch and a write-only direction
  register loaded from the working register.
  assumes the core presents one request per instruction cycle, one
  ref_clk cycle long; pins are resolved by the surroundings from
  out/oe.
*/
`include "bio_map.svh"

module bio_ports
  import bio_pkg::*;
#(
  parameter bit HAS_GROUP_C = 1'b1
) (
  // clock and reset
  input  wire logic      ref_clk,
  input  wire logic      rst_n,
  // core access
  input  wire bio_req_s  req,
  output bio_byte_t      rdata_q,
  output logic           rvalid_q,
  // pins
  input  wire bio_byte_t group_a_pin_in,
  input  wire bio_byte_t group_b_pin_in,
  input  wire bio_byte_t group_c_pin_in,
  output bio_pins_s      group_a_pins_q,
  output bio_pins_s      group_b_pins_q,
  output bio_pins_s      group_c_pins_q
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  bio_byte_t latch_q [3];
  bio_byte_t dir_q   [3];
  bio_byte_t lvl     [3];
  bio_byte_t pin_in  [3];
  bio_pins_s pins_q  [3];

  assign pin_in[0] = group_a_pin_in;
  assign pin_in[1] = group_b_pin_in;
  assign pin_in[2] = group_c_pin_in;

  // map a file address to a port index; 3 means not a port
  function automatic logic [1:0] port_idx(input bio_faddr_t a);
    unique case (a)
      `BIO_ADDR_GROUP_A: port_idx = 2'd0;
      `BIO_ADDR_GROUP_B: port_idx = 2'd1;
      `BIO_ADDR_GROUP_C: port_idx = 2'd2;
      default:           port_idx = 2'd3;
    endcase
  endfunction

  // width mask per port
  function automatic bio_byte_t port_mask(input logic [1:0] i);
    port_mask = (i == 2'd0) ? `BIO_GROUP_A_MASK : 8'hFF;
  endfunction

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  // inputs are not latched; the three-stage path adds latency, so the
  // outside must hold a level a few cycles before the read
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      bio_sync u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .pin_in  (pin_in[g]),
        .level_q (lvl[g])
      );
    end
  endgenerate

  logic [1:0] idx;
  logic       is_pin;
  bio_byte_t  sampled;
  bio_byte_t  rmw;

  assign idx    = port_idx(req.addr);
  // without group c its address is plain storage, read from the latch
  assign is_pin = (idx != 2'd3) && (HAS_GROUP_C || idx != 2'd2);

  always_comb begin
    sampled = `BIO_ZERO;
    if (is_pin) begin
      sampled = lvl[idx] & port_mask(idx);
    end else if (idx == 2'd2) begin
      sampled = latch_q[2];
    end
  end

  // bit op: sampled pins with one bit changed, every port bit written back (four for group a)
  always_comb begin
    rmw = sampled;
    rmw[req.bit_sel] = req.bit_val;
  end

  // ----------------------------------------------------------------
  // read path: value taken at the start of the cycle
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q  <= `BIO_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= req.rd && (idx != 2'd3);
      if (req.rd && idx != 2'd3) begin
        rdata_q <= sampled;
      end
    end
  end

  // ----------------------------------------------------------------
  // latches and direction registers
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < 3; g++) begin : g_port
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          latch_q[g] <= `BIO_LATCH_RESET;
        end else if (idx == g[1:0] && req.bit_op) begin
          latch_q[g] <= rmw & port_mask(g[1:0]);
        end else if (idx == g[1:0] && req.wr) begin
          latch_q[g] <= req.wdata & port_mask(g[1:0]);
        end
      end

      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          dir_q[g] <= `BIO_DIR_RESET;
        end else if (req.dir_ld && idx == g[1:0]) begin
          dir_q[g] <= req.wdata;
        end
      end

      // outputs registered; direction one disables the driver
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          pins_q[g] <= '0;
        end else if (g == 2 && !HAS_GROUP_C) begin
          pins_q[g] <= '0;
        end else begin
          pins_q[g].out <= latch_d(g[1:0]) & port_mask(g[1:0]);
          pins_q[g].oe  <= ~dir_d(g[1:0]) & port_mask(g[1:0]);
        end
      end
    end
  endgenerate

  // next latch / direction values so the pins follow in the same edge
  function automatic bio_byte_t latch_d(input logic [1:0] i);
    if (idx == i && req.bit_op) latch_d = rmw;
    else if (idx == i && req.wr) latch_d = req.wdata;
    else latch_d = latch_q[i];
  endfunction

  function automatic bio_byte_t dir_d(input logic [1:0] i);
    if (req.dir_ld && idx == i) dir_d = req.wdata;
    else dir_d = dir_q[i];
  endfunction

  assign group_a_pins_q = pins_q[0];
  assign group_b_pins_q = pins_q[1];
  assign group_c_pins_q = pins_q[2];

endmodule // bio_ports

// *** testbench/bio_chk.sv ***
/*
  checker for bio_ports: request to answer timing on group b and reads.
  assumes one request per cycle on req and is bound to every bio_ports instance.
*/
module bio_chk
  import bio_pkg::*;
(
  // watched ports
  input wire logic      ref_clk,
  input wire logic      rst_n,
  input wire bio_req_s  req,
  input wire bio_byte_t rdata_q,
  input wire logic      rvalid_q,
  input wire bio_pins_s group_a_pins_q,
  input wire bio_pins_s group_b_pins_q
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic hb = req.addr == 5'h06;
  wire logic ok = req.addr >= 5'h05 && req.addr <= 5'h07;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_rst_float: assert property ($rose(rst_n) |->
    (group_a_pins_q.oe | group_b_pins_q.oe) == 8'h00) else $error("oe");
  chk_wr_latch: assert property (req.wr && !req.bit_op && hb |=>
    group_b_pins_q.out == $past(req.wdata)) else $error("latch");
  chk_dir_load: assert property (req.dir_ld && hb |=>
    group_b_pins_q.oe == ~$past(req.wdata)) else $error("dir");
  chk_rd_answer: assert property (req.rd && ok |=> rvalid_q)
    else $error("no rvalid");
  chk_rd_refuse: assert property (!(req.rd && ok) |=>
    !rvalid_q) else $error("stray rvalid");
  chk_a_upper: assert property (req.rd && req.addr == 5'h05 |=>
    rdata_q[7:4] == 4'h0) else $error("upper bits");
  chk_out_hold: assert property (!((req.wr || req.bit_op) && hb) |=>
    $stable(group_b_pins_q.out)) else $error("latch moved");
  chk_dir_only: assert property (!(req.dir_ld && hb) |=>
    $stable(group_b_pins_q.oe)) else $error("oe moved");
endmodule // bio_chk

bind bio_ports bio_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .req(req),
  .rdata_q(rdata_q), .rvalid_q(rvalid_q), .group_a_pins_q(group_a_pins_q),
  .group_b_pins_q(group_b_pins_q));

// *** testbench/bio_pin_model.sv ***
/*
  external circuitry on the pins: a driven pin follows its latch.
  assumes the bench holds the outside levels steady until read.
*/
module bio_pin_model
  import bio_pkg::*;
(
  // from the ports and the outside world
  input  wire bio_pins_s a,
  input  wire bio_pins_s b,
  input  wire bio_pins_s c,
  input  wire bio_byte_t ext_a,
  input  wire bio_byte_t ext_b,
  input  wire bio_byte_t ext_c,
  // resolved pin levels
  output bio_byte_t      pin_a,
  output bio_byte_t      pin_b,
  output bio_byte_t      pin_c
);
  timeunit 1ns;
  timeprecision 1ns;
  assign pin_a = (a.out & a.oe) | (ext_a & ~a.oe);
  assign pin_b = (b.out & b.oe) | (ext_b & ~b.oe);
  assign pin_c = (c.out & c.oe) | (ext_c & ~c.oe);
endmodule // bio_pin_model

// *** testbench/testbench.sv ***
/*
  self-checking bench for bio_ports.
  assumes the pin model resolves every pin from latch and direction.
*/
module testbench
  import bio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic      ref_clk = 1'b0;
  logic      rst_n   = 1'b0;
  bio_req_s  req     = '0;
  bio_byte_t ext_a   = 8'h00;
  bio_byte_t ext_b   = 8'h00;
  bio_byte_t ext_c   = 8'h00;
  bio_byte_t rdata_q, pin_a, pin_b, pin_c, got;
  logic      rvalid_q, gv;
  bio_pins_s pa, pb, pc;
  bio_byte_t rdata_nc, got_nc;
  bio_pins_s pc_nc;
  int        fails = 0;
  int        checks = 0;
  bio_ports #(.HAS_GROUP_C(1'b1)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .req(req), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
    .group_a_pin_in(pin_a), .group_b_pin_in(pin_b), .group_c_pin_in(pin_c),
    .group_a_pins_q(pa), .group_b_pins_q(pb), .group_c_pins_q(pc));
  bio_pin_model u_pins (.a(pa), .b(pb), .c(pc), .ext_a(ext_a),
    .ext_b(ext_b), .ext_c(ext_c), .pin_a(pin_a), .pin_b(pin_b),
    .pin_c(pin_c));
  // same requests into a build without group c
  bio_ports #(.HAS_GROUP_C(1'b0)) dut_nc (.ref_clk(ref_clk), .rst_n(rst_n),
    .req(req), .rdata_q(rdata_nc), .rvalid_q(),
    .group_a_pin_in(pin_a), .group_b_pin_in(pin_b), .group_c_pin_in(pin_c),
    .group_a_pins_q(), .group_b_pins_q(), .group_c_pins_q(pc_nc));
  initial forever #50 ref_clk = ~ref_clk;
  task automatic chk(input bio_byte_t g, input bio_byte_t e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one instruction, then idle long enough for pins to pass the sync
  task automatic op(input bio_req_s r);
    req = r;
    @(negedge ref_clk);
    got = rdata_q;
    got_nc = rdata_nc;
    gv = rvalid_q;
    req = '0;
    repeat (5) @(negedge ref_clk);
  endtask
  task automatic wr(input bio_faddr_t a, input bio_byte_t d, input logic dl);
    op('{wr: !dl, dir_ld: dl, addr: a, wdata: d, default: '0});
  endtask
  task automatic rd(input bio_faddr_t a, input bio_byte_t e);
    op('{rd: 1'b1, addr: a, default: '0});
    chk(got, e);
    chk({7'h00, gv}, 8'h01);
  endtask
  task automatic conclude();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (1000) @(posedge ref_clk);
    fails++;
    conclude();
  end
  initial begin
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    chk(pa.oe | pb.oe | pc.oe, 8'h00);
    ext_a = 8'hFF;
    ext_b = 8'hC3;
    wr(5'h06, 8'h5A, 1'b0);
    wr(5'h06, 8'h0F, 1'b1);
    chk(pb.out, 8'h5A);
    chk(pb.oe, 8'hF0);
    rd(5'h06, 8'h53);
    wr(5'h06, 8'hFF, 1'b1);
    chk(pb.out, 8'h5A);
    $display("test group b done");
    wr(5'h06, 8'hF0, 1'b1);
    op('{bit_op: 1'b1, bit_val: 1'b1, bit_sel: 3'd4, addr: 5'h06,
      default: '0});
    chk(pb.out, 8'hDA);
    rd(5'h05, 8'h0F);
    wr(5'h07, 8'h3C, 1'b0);
    rd(5'h07, 8'h00);
    chk(got_nc, 8'h3C);
    wr(5'h07, 8'h00, 1'b1);
    rd(5'h07, 8'h3C);
    chk(pc_nc.out | pc_nc.oe, 8'h00);
    wr(5'h08, 8'hFF, 1'b1);
    chk(pc.oe, 8'hFF);
    op('{rd: 1'b1, addr: 5'h01, default: '0});
    chk({7'h00, gv}, 8'h00);
    $display("test mixed done");
    // reset in mid-run puts every pin back to input
    rst_n = 1'b0;
    @(negedge ref_clk);
    chk(pb.oe | pc.oe, 8'h00);
    rst_n = 1'b1;
    wr(5'h06, 8'hA5, 1'b0);
    chk(pb.out, 8'hA5);
    chk(pb.oe, 8'h00);
    $display("test reset done");
    conclude();
  end
endmodule // testbench
